// file: core/usb_status_control_pkg.sv
// Shared constants and types for the USB status and control register bank
package usb_status_control_pkg;

    // ------------------------------------------------------------
    // Register offsets on the 8-bit port
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL_ONE = 8'h05;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h06;
    localparam logic [7:0] OFS_USB_ADDRESS = 8'h07;
    localparam logic [7:0] OFS_INTERRUPT_FLAGS = 8'h0d;
    localparam logic [7:0] OFS_CURRENT_BUFFER_SELECT = 8'h0e;
    localparam logic [7:0] OFS_ROLE_POLARITY_CONTROL = 8'h0f;
    localparam logic [7:0] OFS_FRAME_NUMBER_LOW = 8'h15;
    localparam logic [7:0] OFS_FRAME_NUMBER_HIGH = 8'h16;
    localparam logic [7:0] OFS_DMA_BYTE_COUNT_LOW = 8'h35;
    localparam logic [7:0] OFS_DMA_BYTE_COUNT_HIGH = 8'h36;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FLAG_DMA_BUSY = 7;
    localparam int FLAG_USB_RESET = 6;
    localparam int FLAG_SOF = 5;
    localparam int FLAG_DMA_DONE = 4;
    localparam int CTL1_USB_ENABLE = 0;
    localparam int CTL1_DMA_ENABLE = 1;
    localparam int CTL1_DMA_DIR = 2;
    localparam int CTL1_JK_LO = 3;
    localparam int CTL1_JK_HI = 4;
    localparam int CTL1_SPEED_LOW = 5;
    localparam int CTL1_STANDBY = 6;
    localparam int CTL2_HOST_ROLE = 7;
    localparam int CTL2_POLARITY_SWAP = 6;
    localparam int ENDPOINTS = 4;
    localparam int FRAME_BITS = 11;
    localparam int FRAME_LOW_BITS = 7;

    // Masks of writable and readable bits
    localparam logic [7:0] CTL1_WRITE_MASK = 8'h7f;
    localparam logic [7:0] CTL2_WRITE_MASK = 8'hc0;
    localparam logic [7:0] EVENT_FLAG_MASK = 8'h7f;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {
        DMA_IDLE,
        DMA_BUSY
    } dma_state_t;

    // Events reported by the USB engine; reset, frame start, DMA done and endpoint done are one-cycle pulses
    typedef struct packed {
        logic usb_reset;
        logic sof;
        logic [FRAME_BITS-1:0] frame;
        logic dma_done;
        logic [ENDPOINTS-1:0] endpoint_done;
        logic [ENDPOINTS-1:0] buffer_select;
    } engine_events_t;

    // Control levels handed to the USB engine
    typedef struct packed {
        logic usb_enable;
        logic dma_enable;
        logic dma_read_dir;
        logic [1:0] line_force;
        logic speed_low;
        logic standby;
        logic host_role;
        logic polarity_swap;
        logic [7:0] usb_address;
        logic [15:0] dma_count;
        logic dma_start;
        logic dma_busy;
        logic endpoint_three_via_dma;
    } engine_controls_t;

endpackage

// file: core/usb_status_control_regs.sv
// Status and control register bank of a USB host/peripheral controller
`timescale 1ns/10ps
// How it works
// - Reading flags returns pending events; writing ones clears the matching flags.
// - Zero bits written to the flag register leave those flags alone.
// - Flag bit 7 is high while DMA runs, low after it completes.
// - The DMA busy bit never raises the interrupt when it falls.
// - Bits 6,5,4,3..0 latch bus reset, frame start, DMA done, endpoint done.
// - Buffer select bits 3..0 show endpoint buffer a (0) or b (1).
// - Buffer select bits 7..4 are reserved and read zero.
// - Role control bit 7 picks host (1) or peripheral (0).
// - Role control bit 6 swaps D+ and D- polarity for low speed.
// - Frame low holds frame bits in 7..1, refreshed on each frame start.
// - Frame high holds four more frame bits in 7..4; software masks 3..0.
// - DMA byte count is sixteen bits from a low and high register.
// - Writing count high starts DMA when DMA enable is already set.
// - Endpoint three moves data only through DMA.
// - Interrupt output asserts only for pending flags whose enable is set.
// - DMA enable is control one bit 1; the high count write launches.

module usb_status_control_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Microprocessor port
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic addr_sel,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    // Interrupt
    output logic interrupt_request_out,
    // USB engine side
    input wire usb_status_control_pkg::engine_events_t events,
    output usb_status_control_pkg::engine_controls_t controls
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic prev_write;
        logic prev_read;
        logic [7:0] pointer;
        logic [7:0] read_data;
        logic [7:0] control_one;
        logic [7:0] irq_enable;
        logic [7:0] usb_address;
        logic [7:0] flags;
        logic [7:0] role_polarity;
        logic [usb_status_control_pkg::FRAME_BITS-1:0] frame;
        logic [7:0] count_low;
        logic [7:0] count_high;
        usb_status_control_pkg::dma_state_t dma_state;
        logic dma_start;
        logic irq;
    } state_t;

    state_t state_q;
    state_t state_d;

    logic write_active;
    logic read_active;
    logic write_strobe;
    logic read_strobe;
    logic reg_write;
    logic [7:0] event_set;
    logic [7:0] flag_clear;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic hits(input logic [7:0] pointer, input logic [7:0] offset);
        hits = (pointer == offset);
    endfunction

    // Read multiplexer; undefined and reserved bits read as zero
    function automatic logic [7:0] read_value(input state_t s, input logic [3:0] buf_sel);
        logic [7:0] v;
        v = usb_status_control_pkg::RESET_BYTE;
        case (s.pointer)
            usb_status_control_pkg::OFS_CONTROL_ONE: begin
                v = s.control_one;
            end
            usb_status_control_pkg::OFS_IRQ_ENABLE: begin
                v = s.irq_enable;
            end
            usb_status_control_pkg::OFS_USB_ADDRESS: begin
                v = s.usb_address;
            end
            usb_status_control_pkg::OFS_INTERRUPT_FLAGS: begin
                v = s.flags;
                v[usb_status_control_pkg::FLAG_DMA_BUSY] =
                    (s.dma_state == usb_status_control_pkg::DMA_BUSY);
            end
            usb_status_control_pkg::OFS_CURRENT_BUFFER_SELECT: begin
                v[usb_status_control_pkg::ENDPOINTS-1:0] = buf_sel;
            end
            usb_status_control_pkg::OFS_ROLE_POLARITY_CONTROL: begin
                v = s.role_polarity;
            end
            usb_status_control_pkg::OFS_FRAME_NUMBER_LOW: begin
                v[$high(v) -: usb_status_control_pkg::FRAME_LOW_BITS] =
                    s.frame[usb_status_control_pkg::FRAME_LOW_BITS-1:0];
            end
            usb_status_control_pkg::OFS_FRAME_NUMBER_HIGH: begin
                v[$high(v) -: usb_status_control_pkg::FRAME_BITS -
                    usb_status_control_pkg::FRAME_LOW_BITS] =
                    s.frame[usb_status_control_pkg::FRAME_BITS-1:
                            usb_status_control_pkg::FRAME_LOW_BITS];
            end
            usb_status_control_pkg::OFS_DMA_BYTE_COUNT_LOW: begin
                v = s.count_low;
            end
            usb_status_control_pkg::OFS_DMA_BYTE_COUNT_HIGH: begin
                v = s.count_high;
            end
            default: begin
                v = usb_status_control_pkg::RESET_BYTE;
            end
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Port strobes
    // ------------------------------------------------------------
    // Each access acts once, on the first cycle the strobe is seen low
    assign write_active = !chip_select_n && !write_n;
    assign read_active = !chip_select_n && !read_n && write_n;
    assign write_strobe = write_active && !state_q.prev_write;
    assign read_strobe = read_active && !state_q.prev_read;
    assign reg_write = write_strobe && addr_sel;

    // ------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------
    always_comb begin
        event_set = usb_status_control_pkg::RESET_BYTE;
        event_set[usb_status_control_pkg::FLAG_USB_RESET] = events.usb_reset;
        event_set[usb_status_control_pkg::FLAG_SOF] = events.sof;
        event_set[usb_status_control_pkg::FLAG_DMA_DONE] =
            events.dma_done && (state_q.dma_state == usb_status_control_pkg::DMA_BUSY);
        event_set[usb_status_control_pkg::ENDPOINTS-1:0] = events.endpoint_done;
        flag_clear = usb_status_control_pkg::RESET_BYTE;
        if (reg_write && hits(state_q.pointer, usb_status_control_pkg::OFS_INTERRUPT_FLAGS)) begin
            flag_clear = data_in & usb_status_control_pkg::EVENT_FLAG_MASK;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.prev_write = write_active;
        state_d.prev_read = read_active;
        state_d.dma_start = 1'b0;

        // Set wins over a clear landing in the same cycle
        state_d.flags = ((state_q.flags & ~flag_clear) | event_set)
            & usb_status_control_pkg::EVENT_FLAG_MASK;

        if (events.sof) begin
            state_d.frame = events.frame;
        end

        // DMA completion drops the busy bit; the DMA done flag is set above only if DMA was busy
        if (events.dma_done) begin
            state_d.dma_state = usb_status_control_pkg::DMA_IDLE;
        end

        if (write_strobe && !addr_sel) begin
            state_d.pointer = data_in;
        end

        if (reg_write) begin
            case (state_q.pointer)
                usb_status_control_pkg::OFS_CONTROL_ONE: begin
                    state_d.control_one = data_in & usb_status_control_pkg::CTL1_WRITE_MASK;
                end
                usb_status_control_pkg::OFS_IRQ_ENABLE: begin
                    state_d.irq_enable = data_in;
                end
                usb_status_control_pkg::OFS_USB_ADDRESS: begin
                    state_d.usb_address = data_in;
                end
                usb_status_control_pkg::OFS_ROLE_POLARITY_CONTROL: begin
                    state_d.role_polarity =
                        data_in & usb_status_control_pkg::CTL2_WRITE_MASK;
                end
                usb_status_control_pkg::OFS_DMA_BYTE_COUNT_LOW: begin
                    state_d.count_low = data_in;
                end
                usb_status_control_pkg::OFS_DMA_BYTE_COUNT_HIGH: begin
                    state_d.count_high = data_in;
                    // The low byte is assumed written already
                    if (state_q.control_one[usb_status_control_pkg::CTL1_DMA_ENABLE]) begin
                        state_d.dma_start = 1'b1;
                        state_d.dma_state = usb_status_control_pkg::DMA_BUSY;
                    end
                end
                default: begin
                    // Flags are handled above; frame registers are read only
                end
            endcase
        end

        // Auto-increment is left out: one pointer write per access
        if (read_strobe) begin
            if (addr_sel) begin
                state_d.read_data = read_value(state_q, events.buffer_select);
            end else begin
                state_d.read_data = state_q.pointer;
            end
        end

        // Enables gate only the output, the stored flags are untouched
        state_d.irq = |(state_d.flags & state_d.irq_enable
            & usb_status_control_pkg::EVENT_FLAG_MASK);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign data_out = state_q.read_data;
    // Driven while the read strobe stays low after the data is captured
    assign data_oe_n = !(read_active && state_q.prev_read);
    assign interrupt_request_out = state_q.irq;

    always_comb begin
        controls.usb_enable = state_q.control_one[usb_status_control_pkg::CTL1_USB_ENABLE];
        controls.dma_enable = state_q.control_one[usb_status_control_pkg::CTL1_DMA_ENABLE];
        controls.dma_read_dir = state_q.control_one[usb_status_control_pkg::CTL1_DMA_DIR];
        controls.line_force = state_q.control_one[usb_status_control_pkg::CTL1_JK_HI:
                                                  usb_status_control_pkg::CTL1_JK_LO];
        controls.speed_low = state_q.control_one[usb_status_control_pkg::CTL1_SPEED_LOW];
        controls.standby = state_q.control_one[usb_status_control_pkg::CTL1_STANDBY];
        controls.host_role =
            state_q.role_polarity[usb_status_control_pkg::CTL2_HOST_ROLE];
        controls.polarity_swap =
            state_q.role_polarity[usb_status_control_pkg::CTL2_POLARITY_SWAP];
        controls.usb_address = state_q.usb_address;
        controls.dma_count = {state_q.count_high, state_q.count_low};
        controls.dma_start = state_q.dma_start;
        controls.dma_busy = (state_q.dma_state == usb_status_control_pkg::DMA_BUSY);
        // Endpoint three has no programmed data path; it moves only under DMA
        controls.endpoint_three_via_dma = controls.dma_busy;
    end

endmodule

// file: test/usb_cpu_model.sv
// Microprocessor model driving the two-phase register port
`timescale 1ns/10ps
module usb_cpu_model (
    // Clock
    input wire logic clk,
    // Port towards the register bank
    output logic chip_select_n,
    output logic read_n,
    output logic write_n,
    output logic addr_sel,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n
);
    initial begin
        chip_select_n = 1'b1;
        read_n = 1'b1;
        write_n = 1'b1;
        addr_sel = 1'b0;
        data_in = 8'h00;
    end
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Released data lines show the inverse so stale values never match
    task automatic put(input logic sel, input logic [7:0] val);
        @(negedge clk);
        chip_select_n = 1'b0;
        write_n = 1'b0;
        addr_sel = sel;
        data_in = val;
        @(negedge clk);
        chip_select_n = 1'b1;
        write_n = 1'b1;
        data_in = ~val;
    endtask
    task automatic write_reg(input logic [7:0] ofs, input logic [7:0] val);
        put(1'b0, ofs);
        put(1'b1, val);
    endtask
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] val, output logic oe_n);
        put(1'b0, ofs);
        @(negedge clk);
        chip_select_n = 1'b0;
        read_n = 1'b0;
        addr_sel = 1'b1;
        @(negedge clk);
        val = data_out;
        oe_n = data_oe_n;
        chip_select_n = 1'b1;
        read_n = 1'b1;
    endtask
endmodule

// file: test/usb_status_control_regs_chk.sv
// Assertion checker for the USB status and control register bank
`timescale 1ns/10ps
module usb_status_control_regs_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Microprocessor port
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic addr_sel,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n,
    // Interrupt
    input wire logic interrupt_request_out,
    // Engine side
    input wire usb_status_control_pkg::engine_events_t events,
    input wire usb_status_control_pkg::engine_controls_t controls
);
    logic wr_low_q, rd_low_q, wr_take, rd_take;
    logic [7:0] ptr_q;
    logic [7:0] en_q;
    // A held strobe counts once, so only its first edge is an access
    assign wr_take = !chip_select_n && !write_n && !wr_low_q;
    assign rd_take = !chip_select_n && !read_n && write_n && !rd_low_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_low_q <= 1'b0;
            rd_low_q <= 1'b0;
            ptr_q <= 8'h00;
            en_q <= 8'h00;
        end else begin
            wr_low_q <= !chip_select_n && !write_n;
            rd_low_q <= !chip_select_n && !read_n && write_n;
            if (wr_take && !addr_sel) begin
                ptr_q <= data_in;
            end
            // Mirror of the enable register, taken on the same edge as the bank
            if (wr_take && addr_sel && ptr_q == 8'h06) begin
                en_q <= data_in;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_reg_wr(logic [7:0] ofs);
        wr_take && addr_sel && ptr_q == ofs;
    endsequence
    sequence s_reg_rd(logic [7:0] ofs);
        rd_take && addr_sel && ptr_q == ofs;
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    chk_oe_release:
        assert property ((read_n || chip_select_n) |-> data_oe_n) else $error("bus driven idle");
    chk_start_pulse:
        assert property (s_reg_wr(8'h36) ##0 controls.dma_enable |=> controls.dma_start)
        else $error("no dma start");
    chk_start_cause:
        assert property (controls.dma_start |->
            $past(wr_take && addr_sel && ptr_q == 8'h36 && controls.dma_enable))
        else $error("stray dma start");
    chk_busy_drop:
        assert property (controls.dma_busy && events.dma_done && !wr_take |=> !controls.dma_busy)
        else $error("busy kept");
    chk_ep3_dma:
        assert property ($rose(controls.endpoint_three_via_dma) |-> controls.dma_start)
        else $error("endpoint three path");
    chk_irq_gate:
        assert property (!(|en_q[6:0]) |-> !interrupt_request_out)
        else $error("interrupt without enable");
    chk_role_bits:
        assert property (s_reg_wr(8'h0f) |=> controls.host_role == $past(data_in[7])
            && controls.polarity_swap == $past(data_in[6])) else $error("role bits");
    chk_count_low:
        assert property (s_reg_wr(8'h35) |=> controls.dma_count[7:0] == $past(data_in))
        else $error("count low");
    chk_buffer_read:
        assert property (s_reg_rd(8'h0e) |=> data_out == {4'h0, $past(events.buffer_select)})
        else $error("buffer select");
    chk_flag_busy:
        assert property (s_reg_rd(8'h0d) |=> data_out[7] == $past(controls.dma_busy))
        else $error("busy flag");
endmodule
bind usb_status_control_regs usb_status_control_regs_chk u_usb_status_control_regs_chk (
    .clk, .reset_n, .chip_select_n, .read_n, .write_n, .addr_sel, .data_in, .data_out,
    .data_oe_n, .interrupt_request_out, .events, .controls);

// file: test/usb_status_control_regs_tb.sv
// Self-checking testbench for the USB status and control register bank
`timescale 1ns/10ps
module usb_status_control_regs_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic chip_select_n, read_n, write_n, addr_sel, data_oe_n, interrupt_request_out, rd_oe_n;
    logic [7:0] data_in, data_out, rd_val;
    usb_status_control_pkg::engine_events_t events = '0;
    usb_status_control_pkg::engine_controls_t controls;
    int bad_count = 0;
    int total_checks = 0;
    always #25 clk = ~clk;
    usb_status_control_regs u_usb_status_control_regs (.clk, .reset_n, .chip_select_n, .read_n,
        .write_n, .addr_sel, .data_in, .data_out, .data_oe_n, .interrupt_request_out, .events,
        .controls);
    usb_cpu_model u_usb_cpu_model (.clk, .chip_select_n, .read_n, .write_n, .addr_sel,
        .data_in, .data_out, .data_oe_n);
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
        u_usb_cpu_model.write_reg(ofs, val);
    endtask
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        u_usb_cpu_model.read_reg(ofs, rd_val, rd_oe_n);
        check({8'h00, rd_val}, {8'h00, exp});
        check({15'h0000, rd_oe_n}, 16'h0000);
    endtask
    // Bits in flag order: bus reset, frame start, dma done, endpoints 3..0
    task automatic pulse(input logic [6:0] evs);
        @(negedge clk);
        {events.usb_reset, events.sof, events.dma_done, events.endpoint_done} = evs;
        @(negedge clk);
        {events.usb_reset, events.sof, events.dma_done, events.endpoint_done} = 7'h00;
    endtask
    // The request output is registered, so give it one cycle to settle
    task automatic irq(input logic exp);
        @(negedge clk);
        check({15'h0000, interrupt_request_out}, {15'h0000, exp});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #(5000 * 50);
        bad_count++;
        stop_test;
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        rd(8'h0d, 8'h00);
        wr(8'h0f, 8'hff);
        rd(8'h0f, 8'hc0);
        wr(8'h0f, 8'h40);
        check({14'h0000, controls.host_role, controls.polarity_swap}, 16'h0001);
        events.frame = 11'h5a3;
        events.buffer_select = 4'ha;
        pulse(7'h6f);
        rd(8'h0d, 8'h6f);
        irq(1'b0);
        rd(8'h15, 8'h46);
        rd(8'h16, 8'hb0);
        wr(8'h0e, 8'hff);
        rd(8'h0e, 8'h0a);
        wr(8'h0d, 8'h05);
        rd(8'h0d, 8'h6a);
        wr(8'h06, 8'h02);
        irq(1'b1);
        wr(8'h0d, 8'h02);
        irq(1'b0);
        wr(8'h06, 8'h80);
        wr(8'h05, 8'h00);
        wr(8'h35, 8'h34);
        wr(8'h36, 8'h12);
        check({15'h0000, controls.dma_busy}, 16'h0000);
        check(controls.dma_count, 16'h1234);
        wr(8'h05, 8'h02);
        wr(8'h35, 8'hcd);
        wr(8'h36, 8'h00);
        check({14'h0000, controls.dma_start, controls.dma_busy}, 16'h0003);
        check(controls.dma_count, 16'h00cd);
        check({15'h0000, controls.endpoint_three_via_dma}, 16'h0001);
        rd(8'h0d, 8'he8);
        pulse(7'h10);
        irq(1'b0);
        rd(8'h0d, 8'h78);
        wr(8'h06, 8'h10);
        irq(1'b1);
        wr(8'h0d, 8'h7f);
        rd(8'h0d, 8'h00);
        irq(1'b0);
        wr(8'h05, 8'h7d);
        rd(8'h05, 8'h7d);
        check({9'h000, controls.standby, controls.speed_low, controls.line_force,
            controls.dma_read_dir, controls.dma_enable, controls.usb_enable}, 16'h007d);
        wr(8'h07, 8'h5c);
        rd(8'h07, 8'h5c);
        check({8'h00, controls.usb_address}, 16'h005c);
        rd(8'h20, 8'h00);
        stop_test;
    end
endmodule
